// [rtl/cache_err_pkg.sv]
package cache_err_pkg;

    // Avalon word addresses, one 32-bit word each; the 64-bit status register takes two
    localparam logic [2:0] ADDR_STATUS_LO = 3'h0;
    localparam logic [2:0] ADDR_STATUS_HI = 3'h1;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h2;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h3;
    localparam logic [2:0] ADDR_CONTROL = 3'h4;

    // Field positions in the 64-bit status register
    localparam int TAG_CODE_LSB = 16;
    localparam int DATA_CODE_LSB = 18;
    localparam int ORIGIN_BIT = 20;
    localparam int BAD_IRQ_BIT = 21;
    localparam int COUNT_LSB = 32;
    localparam int VALID_LSB = 57;

    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [1:0] CODE_NONE = 2'h0;
    localparam logic [15:0] MCA_CODE_RESET = 16'h0000;
    localparam logic [6:0] VALID_RESET = 7'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // Interrupt status / mask bit positions
    localparam int IRQ_ERR_BIT = 0;
    localparam int IRQ_SAT_BIT = 1;
    localparam int IRQ_BAD_BIT = 2;

    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    typedef struct packed {
        logic valid;
        logic [15:0] mca_code;
        logic [1:0] tag_code;
        logic [1:0] data_code;
        logic third_level;
        logic bad_irq_space_access;
        logic [6:0] validity;
    } cache_err_event_t;

    typedef struct packed {
        logic [6:0] validity;
        logic [16:0] resv_hi;
        logic [7:0] count;
        logic [9:0] resv_lo;
        logic bad_irq_space_access;
        logic third_level_cache_origin;
        logic [1:0] data_code;
        logic [1:0] tag_code;
        logic [15:0] mca_code;
    } cache_machine_check_status_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_t;

endpackage

// [rtl/cache_error_status_encoder.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - Tag error code in bits 17:16
// - Data error code in bits 19:18
// - Bit 20: one for third-level, zero second-level
// - Bit 21 flags write-back interrupt-space access
// - Counter starts 0, increments from the second logged error on, saturates 255
// - Reset returns counter to initial state
module cache_error_status_encoder
    import cache_err_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire cache_err_pkg::cache_err_event_t err_in,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);
    import cache_err_pkg::*;

    cache_machine_check_status_t status_q, status_d;
    logic [7:0] count_q;
    logic saturate_pulse_q;
    logic [2:0] irq_status_q, irq_status_d;
    logic [2:0] irq_mask_q, irq_mask_d;
    logic capture_en_q, capture_en_d;
    logic irq_q, irq_d;
    bus_state_t bus_q, bus_d;
    logic [31:0] rdata_q, rdata_d;
    logic wait_q, wait_d;
    logic take_err;
    logic wr_hit;

    assign take_err = err_in.valid && capture_en_q;
    assign wr_hit = (bus_q == BUS_ANSWER) && avs_write;

    err_counter u_counter (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .bump(take_err),
        .count_q(count_q),
        .seen_q(),
        .saturate_pulse_q(saturate_pulse_q)
    );

    // Status capture: the latest logged error overwrites the fields
    always_comb begin
        status_d = status_q;
        if (take_err) begin
            status_d.mca_code = err_in.mca_code;
            status_d.tag_code = err_in.tag_code;
            status_d.data_code = err_in.data_code;
            status_d.third_level_cache_origin = err_in.third_level;
            status_d.bad_irq_space_access = err_in.bad_irq_space_access;
            status_d.validity = err_in.validity;
        end
        status_d.count = count_q;
        status_d.resv_lo = '0;
        status_d.resv_hi = '0;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    // Interrupt status, mask and control; set wins over a write-one clear
    always_comb begin
        irq_status_d = irq_status_q;
        irq_mask_d = irq_mask_q;
        capture_en_d = capture_en_q;
        if (wr_hit && avs_byteenable[0]) begin
            case (avs_address)
                ADDR_IRQ_STATUS: irq_status_d = irq_status_q & ~avs_writedata[2:0];
                ADDR_IRQ_MASK: irq_mask_d = avs_writedata[2:0];
                ADDR_CONTROL: capture_en_d = avs_writedata[0];
                default: begin
                end
            endcase
        end
        if (take_err) begin
            irq_status_d[IRQ_ERR_BIT] = 1'b1;
        end
        if (saturate_pulse_q) begin
            irq_status_d[IRQ_SAT_BIT] = 1'b1;
        end
        if (take_err && err_in.bad_irq_space_access) begin
            irq_status_d[IRQ_BAD_BIT] = 1'b1;
        end
        irq_d = |(irq_status_d & irq_mask_d);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status_q <= IRQ_RESET;
            irq_mask_q <= IRQ_RESET;
            capture_en_q <= 1'b1;
            irq_q <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            irq_mask_q <= irq_mask_d;
            capture_en_q <= capture_en_d;
            irq_q <= irq_d;
        end
    end

    // Avalon slave: request seen in idle, answered one cycle later
    always_comb begin
        bus_d = bus_q;
        rdata_d = rdata_q;
        wait_d = 1'b1;
        case (bus_q)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_d = BUS_ANSWER;
                    wait_d = 1'b0;
                    case (avs_address)
                        ADDR_STATUS_LO: rdata_d = status_q[31:0];
                        ADDR_STATUS_HI: rdata_d = status_q[63:32];
                        ADDR_IRQ_STATUS: rdata_d = {29'h0, irq_status_q};
                        ADDR_IRQ_MASK: rdata_d = {29'h0, irq_mask_q};
                        ADDR_CONTROL: rdata_d = {31'h0, capture_en_q};
                        default: rdata_d = UNMAPPED_DATA;
                    endcase
                end
            end
            BUS_ANSWER: begin
                bus_d = BUS_IDLE;
            end
            default: begin
                bus_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_q <= BUS_IDLE;
            rdata_q <= UNMAPPED_DATA;
            wait_q <= 1'b1;
        end else begin
            bus_q <= bus_d;
            rdata_q <= rdata_d;
            wait_q <= wait_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign irq = irq_q;
endmodule

// [rtl/err_counter.sv]
`timescale 1ns/100ps
module err_counter
    import cache_err_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic bump,
    output logic [7:0] count_q,
    output logic seen_q,
    output logic saturate_pulse_q
);
    logic [7:0] count_d;
    logic seen_d;
    logic saturate_pulse_d;

    always_comb begin
        count_d = count_q;
        seen_d = seen_q;
        saturate_pulse_d = 1'b0;
        if (bump) begin
            seen_d = 1'b1;
            if (seen_q && count_q != COUNT_MAX) begin
                count_d = count_q + 8'h01;
                saturate_pulse_d = (count_q == COUNT_MAX - 8'h01);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q <= COUNT_RESET;
            seen_q <= 1'b0;
            saturate_pulse_q <= 1'b0;
        end else begin
            count_q <= count_d;
            seen_q <= seen_d;
            saturate_pulse_q <= saturate_pulse_d;
        end
    end
endmodule

// [verification/cache_error_status_encoder_chk.sv]
`timescale 1ns/100ps
module cache_error_status_encoder_chk
    import cache_err_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire cache_err_pkg::cache_err_event_t err_in,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic [5:0] fld_q;
    logic [7:0] cnt_q;
    logic seen_q;
    logic cap_q;
    wire cap_wr = !avs_waitrequest && avs_write && avs_address == 3'h4 && avs_byteenable[0];
    wire lo = !avs_waitrequest && avs_read && avs_address == 3'h0;
    wire hi = !avs_waitrequest && avs_read && avs_address == 3'h1;
    // Reference copy of the last logged fields and the saturating count
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fld_q <= '0;
            cnt_q <= '0;
            seen_q <= 1'b0;
            cap_q <= 1'b1;
        end else begin
            if (cap_wr) begin
                cap_q <= avs_writedata[0];
            end
            if (err_in.valid && cap_q) begin
                fld_q <= {err_in.bad_irq_space_access, err_in.third_level,
                          err_in.data_code, err_in.tag_code};
                seen_q <= 1'b1;
                if (seen_q && cnt_q != 8'hff) begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end
    sequence ans_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    chk_read_answer: assert property ($rose(avs_read) |=> ans_s)
        else $error("read not answered in one cycle");
    chk_tag_code: assert property (lo |-> avs_readdata[17:16] == fld_q[1:0])
        else $error("tag code wrong");
    chk_data_code: assert property (lo |-> avs_readdata[19:18] == fld_q[3:2])
        else $error("data code wrong");
    chk_origin_bit: assert property (lo && !fld_q[5] |-> avs_readdata[20] == fld_q[4])
        else $error("origin bit wrong");
    chk_bad_request: assert property (lo |-> avs_readdata[21] == fld_q[5])
        else $error("bad request bit wrong");
    chk_err_count: assert property (hi |-> avs_readdata[7:0] == cnt_q)
        else $error("error count wrong");
    chk_zero_lo: assert property (lo |-> avs_readdata[31:22] == 10'h0)
        else $error("low gap not zero");
    chk_zero_hi: assert property (hi |-> avs_readdata[24:8] == 17'h0)
        else $error("high gap not zero");
endmodule
bind cache_error_status_encoder cache_error_status_encoder_chk chk(.core_clk(core_clk),
    .rst_b(rst_b), .err_in(err_in), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// [verification/cache_error_status_encoder_tb.sv]
`timescale 1ns/100ps
module cache_error_status_encoder_tb;
    import cache_err_pkg::*;
    logic core_clk = 0, rst_b = 0, rd = 0, wr = 0, wait_r, irq;
    cache_err_event_t ev = '0;
    logic [2:0] adr = 3'h0;
    logic [31:0] wd = 32'h0, rdata, q;
    int num_errors = 0, comparisons = 0, cyc = 0;
    cache_error_status_encoder dut(.core_clk(core_clk), .rst_b(rst_b), .err_in(ev),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wait_r), .irq(irq));
    initial forever #12.5 core_clk = ~core_clk;
    task test_done;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            test_done();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Hold the request until waitrequest is sampled low
    task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        @(posedge core_clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge core_clk); while (wait_r !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task rchk(input logic [2:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task pulse(input logic [1:0] t, input logic [1:0] d, input logic o, input logic b);
        @(posedge core_clk);
        ev <= '{1'b1, 16'h00a5, t, d, o, b, 7'h41};
        @(posedge core_clk);
        ev.valid <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        rchk(3'h0, 32'h0);
        rchk(3'h1, 32'h0);
        for (int i = 0; i < 4; i++) begin
            pulse(2'(i), 2'(3 - i), i[0], i[1]);
            rchk(3'h0, {10'h0, i[1], i[0], 2'(3 - i), 2'(i), 16'h00a5});
            rchk(3'h1, {7'h41, 17'h0, 8'(i)});
        end
        rchk(3'h5, 32'h0);
        $display("field test done");
        bus(1'b1, 3'h3, 32'h7);
        rchk(3'h2, 32'h5);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, 3'h2, 32'h7);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        for (int i = 0; i < 256; i++) pulse(2'h1, 2'h1, 1'b0, 1'b0);
        rchk(3'h1, {7'h41, 17'h0, 8'hff});
        rchk(3'h2, 32'h3);
        chk({31'h0, irq}, 32'h1);
        $display("saturation test done");
        bus(1'b1, 3'h2, 32'h7);
        bus(1'b1, 3'h3, 32'h0);
        pulse(2'h2, 2'h2, 1'b1, 1'b0);
        chk({31'h0, irq}, 32'h0);
        rchk(3'h2, 32'h1);
        $display("mask test done");
        bus(1'b1, 3'h4, 32'h0);
        rchk(3'h4, 32'h0);
        pulse(2'h1, 2'h1, 1'b0, 1'b1);
        rchk(3'h0, {10'h0, 1'b0, 1'b1, 2'h2, 2'h2, 16'h00a5});
        rchk(3'h1, {7'h41, 17'h0, 8'hff});
        rchk(3'h2, 32'h1);
        bus(1'b1, 3'h4, 32'h1);
        rchk(3'h4, 32'h1);
        $display("capture test done");
        rst_b <= 1'b0;
        @(posedge core_clk);
        rst_b <= 1'b1;
        rchk(3'h1, 32'h0);
        pulse(2'h3, 2'h3, 1'b1, 1'b0);
        rchk(3'h1, {7'h41, 17'h0, 8'h00});
        $display("reset test done");
        test_done();
    end
endmodule
